// ===== design/scu_pkg.sv
// Purpose: shared constants for the card-mode serial port
// Assumes: plain register port, one 16-bit register per word index
// Notes: all register reset values are zero; status reads 0x0100 after reset through its live idle bit
// Function
// (RQ1) guard and wait limits come from their registers, counted in ETUs
// (RQ2) ETU length follows the baud divisor register
// (RQ3) each card event has an enable; its flag stays set until software clears
// (RQ4) enabled card events drive the error interrupt, with enable and priority
// (RQ5) host sets receive mode and divisor ref/372 before card reset
// (RQ6) format field 11 frames eight data bits plus even parity; receive in inverse convention checks odd parity instead
// (RQ7) card mode enable bit 0 of control register turns card operation on
// (RQ8) receiver enable at status bit 12, port enable at mode bit 15
// (RQ9) control fields: protocol bit 1, pulldown bit 2, convention bit 3, retry 5:4
// (RQ10) host clears port enable while reconfiguring after answer to reset
// (RQ11) guard match enable at bit 0, wait match enable at bit 1
// (RQ12) transmitter enable at status bit 10 starts the first transmission
// (RQ13) host never sets transmit and receive enable together
// (RQ14) bit 15 of transmit data marks the final character
// (RQ15) each transmitted character also raises the receive interrupt, except one that ends with the transmit repeat error
// (RQ16) host loads block waiting time for T=1 transmission
// (RQ17) host loads character waiting time for T=1 reception
// (RQ18) host waits out the guard time before answering
// (RQ19) parity error enable in card interrupt register, flag in status
// (RQ20) separate transmit and receive repeat error flags and enables
// (RQ21) 9-bit guard and 24-bit wait counters advance once per ETU
// (RQ22) retries, pulldown and repeat errors apply only under T=0
// (RQ23) counts restart at each character end; flag set on reaching value
// (RQ24) inverse convention inverts data bits and sends MSB first
package scu_pkg;
	localparam logic [3:0] A_MODE = 4'h0;
	localparam logic [3:0] A_STAT = 4'h1;
	localparam logic [3:0] A_TXD  = 4'h2;
	localparam logic [3:0] A_RXD  = 4'h3;
	localparam logic [3:0] A_BAUD = 4'h4;
	localparam logic [3:0] A_CCON = 4'h5;
	localparam logic [3:0] A_CINT = 4'h6;
	localparam logic [3:0] A_GT   = 4'h7;
	localparam logic [3:0] A_WTL  = 4'h8;
	localparam logic [3:0] A_WTH  = 4'h9;
	localparam logic [3:0] A_IRQ  = 4'hA;
	localparam logic [15:0] MODE_WM = 16'h8006;
	localparam logic [15:0] STAT_WM = 16'h1400;
	localparam logic [15:0] CCON_WM = 16'h003F;
	localparam logic [15:0] CIE_WM  = 16'h0073;
	localparam logic [15:0] CIF_WM  = 16'h3300;
	localparam logic [15:0] GT_WM   = 16'h01FF;
	localparam logic [15:0] WTH_WM  = 16'h00FF;
	localparam logic [15:0] IRQ_WM  = 16'h0073;
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam int M_EN = 15;
	localparam int M_FMT = 1;
	localparam logic [1:0] FMT_PAR = 2'h3;
	localparam int S_RXEN = 12;
	localparam int S_TXEN = 10;
	localparam int S_TXFULL = 9;
	localparam int S_IDLE = 8;
	localparam int S_PARITY_ERROR_FLAG = 3;
	localparam int S_RXRDY = 0;
	localparam int C_EN = 0;
	localparam int C_PROT = 1;
	localparam int C_PD = 2;
	localparam int C_CODING_CONVENTION = 3;
	localparam int C_RPT = 4;
	localparam int I_GIE = 0;
	localparam int I_WIE = 1;
	localparam int I_TIE = 4;
	localparam int I_RIE = 5;
	localparam int I_PIE = 6;
	localparam int I_GIF = 8;
	localparam int I_WIF = 9;
	localparam int I_TIF = 12;
	localparam int I_RIF = 13;
	localparam int T_LAST = 15;
	localparam int Q_ERIE = 0;
	localparam int Q_RXIE = 1;
	localparam int Q_PRI = 4;
	typedef enum logic [2:0] {ST_IDLE, ST_TX, ST_CHK, ST_RX, ST_NACK} scu_state_e;
endpackage : scu_pkg

// ===== design/scu_card_port.sv
// Purpose: card-mode serial port on one shared open-drain data line
// Assumes: 40 MHz sys_clk, register port with read data one cycle later
// Notes: line is released for a one, pulled low for a zero
`timescale 1ns/1ps
module scu_card_port (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        card_io_in,
	output logic             card_io_out,
	output logic             card_io_oe,
	output logic             rx_irq,
	output logic             error_irq,
	output logic      [2:0]  error_irq_priority,
	output logic             tx_last_done
);
	logic [15:0] mode_reg, mode_next, stat_reg, stat_next, baud_reg, baud_next;
	logic [15:0] ccon_reg, ccon_next, cint_reg, cint_next, gt_reg, gt_next;
	logic [15:0] wtl_reg, wtl_next, wth_reg, wth_next, irq_reg, irq_next;
	logic [15:0] rdata_reg, rdata_next, etu_reg, etu_next;
	logic [8:0]  txb_reg, txb_next, gtc_reg, gtc_next;
	logic [7:0]  rxd_reg, rxd_next;
	logic [9:0]  sh_reg, sh_next, rsh_reg, rsh_next;
	logic [23:0] wtc_reg, wtc_next;
	logic [3:0]  bit_reg, bit_next;
	logic [2:0]  try_reg, try_next, pcnt_reg, pcnt_next;
	logic        txf_reg, txf_next, rxr_reg, rxr_next, nack_reg, nack_next;
	logic        drv_reg, drv_next, rxi_reg, rxi_next, err_reg, err_next;
	logic        last_reg, last_next, sy1_reg, sy2_reg, prev_reg;
	scu_pkg::scu_state_e st_reg, st_next;
	logic        run, t0, pe, coding_convention, tick, half, fin;
	logic [3:0]  nb;
	logic [2:0]  rlim;
	logic [7:0]  lb, dd;
	logic        pb, pp, tp;

	function automatic logic [7:0] scu_rev(input logic [7:0] d);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = d[7 - i];
		end
		return r;
	endfunction : scu_rev

	assign run = mode_reg[scu_pkg::M_EN] & ccon_reg[scu_pkg::C_EN]; // RQ7 RQ8
	assign t0 = ~ccon_reg[scu_pkg::C_PROT]; // RQ9
	assign pe = (mode_reg[scu_pkg::M_FMT +: 2] == scu_pkg::FMT_PAR); // RQ6
	assign coding_convention = ccon_reg[scu_pkg::C_CODING_CONVENTION];
	assign tick = (etu_reg == baud_reg); // RQ2
	assign half = (etu_reg == (baud_reg >> 1));
	assign nb = pe ? 4'h9 : 4'h8;
	assign rlim = {1'b0, ccon_reg[scu_pkg::C_RPT +: 2]} + 3'h1;
	// received line bits, undone per convention
	assign lb = pe ? rsh_reg[8:1] : rsh_reg[9:2];
	assign dd = coding_convention ? ~scu_rev(lb) : lb; // RQ24
	assign pb = coding_convention ? ~rsh_reg[9] : rsh_reg[9];
	assign pp = coding_convention ? ~(^dd) : ^dd; // RQ24
	// send parity comes from the held byte, not the receive shifter
	assign tp = coding_convention ? ~(^txb_reg[7:0]) : ^txb_reg[7:0]; // RQ6 RQ24
	assign card_io_out = 1'b0;
	assign card_io_oe = drv_reg;
	assign reg_rdata = rdata_reg;
	assign rx_irq = rxi_reg;
	assign error_irq = err_reg;
	assign error_irq_priority = irq_reg[scu_pkg::Q_PRI +: 3]; // RQ4
	assign tx_last_done = last_reg;

	always_comb begin
		mode_next = mode_reg;
		stat_next = stat_reg;
		baud_next = baud_reg;
		ccon_next = ccon_reg;
		cint_next = cint_reg;
		gt_next = gt_reg;
		wtl_next = wtl_reg;
		wth_next = wth_reg;
		irq_next = irq_reg;
		txb_next = txb_reg;
		txf_next = txf_reg;
		rxd_next = rxd_reg;
		rxr_next = rxr_reg;
		st_next = st_reg;
		etu_next = tick ? 16'h0000 : etu_reg + 16'h0001; // RQ2
		bit_next = bit_reg;
		sh_next = sh_reg;
		rsh_next = rsh_reg;
		try_next = try_reg;
		pcnt_next = pcnt_reg;
		nack_next = nack_reg;
		gtc_next = gtc_reg;
		wtc_next = wtc_reg;
		rxi_next = 1'b0;
		last_next = 1'b0;
		rdata_next = 16'h0000;
		fin = 1'b0;
		if (reg_rd) begin
			case (reg_addr)
				scu_pkg::A_MODE: rdata_next = mode_reg;
				scu_pkg::A_STAT: begin
					rdata_next = stat_reg;
					rdata_next[scu_pkg::S_TXFULL] = txf_reg;
					rdata_next[scu_pkg::S_IDLE] = (st_reg == scu_pkg::ST_IDLE);
					rdata_next[scu_pkg::S_RXRDY] = rxr_reg;
				end
				scu_pkg::A_RXD: begin
					rdata_next = {8'h00, rxd_reg};
					rxr_next = 1'b0;
				end
				scu_pkg::A_BAUD: rdata_next = baud_reg;
				scu_pkg::A_CCON: rdata_next = ccon_reg;
				scu_pkg::A_CINT: rdata_next = cint_reg; // RQ3
				scu_pkg::A_GT: rdata_next = gt_reg;
				scu_pkg::A_WTL: rdata_next = wtl_reg;
				scu_pkg::A_WTH: rdata_next = wth_reg;
				scu_pkg::A_IRQ: rdata_next = irq_reg;
				default: rdata_next = 16'h0000;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				scu_pkg::A_MODE: mode_next = reg_wdata & scu_pkg::MODE_WM; // RQ8
				// writing 0 to a flag clears it, writing 1 leaves it
				scu_pkg::A_STAT: stat_next = (reg_wdata & scu_pkg::STAT_WM)
					| (stat_reg & reg_wdata & (16'h0001 << scu_pkg::S_PARITY_ERROR_FLAG));
				scu_pkg::A_TXD: begin
					txb_next = {reg_wdata[scu_pkg::T_LAST], reg_wdata[7:0]}; // RQ14
					txf_next = 1'b1;
				end
				scu_pkg::A_BAUD: baud_next = reg_wdata; // RQ2
				scu_pkg::A_CCON: ccon_next = reg_wdata & scu_pkg::CCON_WM; // RQ9
				scu_pkg::A_CINT: cint_next = (reg_wdata & scu_pkg::CIE_WM)
					| (cint_reg & reg_wdata & scu_pkg::CIF_WM); // RQ3 RQ11
				scu_pkg::A_GT: gt_next = reg_wdata & scu_pkg::GT_WM; // RQ1
				scu_pkg::A_WTL: wtl_next = reg_wdata; // RQ1
				scu_pkg::A_WTH: wth_next = reg_wdata & scu_pkg::WTH_WM;
				scu_pkg::A_IRQ: irq_next = reg_wdata & scu_pkg::IRQ_WM; // RQ4
				default: ;
			endcase
		end
		case (st_reg)
			scu_pkg::ST_IDLE: begin
				if (run && stat_reg[scu_pkg::S_TXEN] && txf_reg) begin // RQ12
					sh_next = {pe ? tp : 1'b1, coding_convention ? ~scu_rev(txb_reg[7:0])
						: txb_reg[7:0], 1'b0}; // RQ6 RQ24
					txf_next = 1'b0;
					try_next = 3'h0;
					etu_next = 16'h0000;
					bit_next = 4'h0;
					st_next = scu_pkg::ST_TX;
				end else if (run && stat_reg[scu_pkg::S_RXEN] && prev_reg && !sy2_reg) begin
					etu_next = 16'h0000;
					bit_next = 4'h0;
					st_next = scu_pkg::ST_RX;
				end
			end
			scu_pkg::ST_TX: begin
				if (tick) begin
					sh_next = {1'b1, sh_reg[9:1]};
					bit_next = bit_reg + 4'h1;
					if (bit_reg == nb) begin
						bit_next = 4'h0;
						nack_next = 1'b0;
						st_next = scu_pkg::ST_CHK;
					end
				end
			end
			scu_pkg::ST_CHK: begin
				// card signals a bad character by holding the line low mid-guard
				if (half && bit_reg == 4'h0) begin
					nack_next = !sy2_reg && t0 && pe; // RQ22
				end
				if (tick) begin
					bit_next = bit_reg + 4'h1;
					if (bit_reg == 4'h1) begin
						if (nack_reg && try_reg < rlim) begin // RQ22
							try_next = try_reg + 3'h1;
							sh_next = {pe ? tp : 1'b1, coding_convention ? ~scu_rev(txb_reg[7:0])
								: txb_reg[7:0], 1'b0};
							bit_next = 4'h0;
							st_next = scu_pkg::ST_TX;
						end else begin
							// shared line: own character is heard by the receiver
							if (nack_reg) begin
								cint_next[scu_pkg::I_TIF] = 1'b1; // RQ20
							end else begin
								rxd_next = txb_reg[7:0]; // RQ15
								rxr_next = 1'b1;
								rxi_next = irq_reg[scu_pkg::Q_RXIE]; // RQ15
							end
							last_next = txb_reg[8]; // RQ14
							fin = 1'b1;
						end
					end
				end
			end
			scu_pkg::ST_RX: begin
				if (half) begin
					rsh_next = {sy2_reg, rsh_reg[9:1]};
					if (bit_reg == 4'h0 && sy2_reg) begin
						st_next = scu_pkg::ST_IDLE;
					end
				end
				if (tick) begin
					bit_next = bit_reg + 4'h1;
					if (bit_reg == nb) begin
						bit_next = 4'h0;
						if (pe && (pb != pp)) begin
							stat_next[scu_pkg::S_PARITY_ERROR_FLAG] = 1'b1; // RQ19
							if (t0) begin
								pcnt_next = pcnt_reg + 3'h1;
								st_next = scu_pkg::ST_NACK; // RQ22
								// last refused copy still gets its nack
								if (pcnt_reg + 3'h1 >= rlim) begin
									cint_next[scu_pkg::I_RIF] = 1'b1; // RQ20
									pcnt_next = 3'h0;
								end
							end else begin
								rxd_next = dd;
								rxr_next = 1'b1;
								rxi_next = irq_reg[scu_pkg::Q_RXIE];
								fin = 1'b1;
							end
						end else begin
							rxd_next = dd; // RQ24
							rxr_next = 1'b1;
							rxi_next = irq_reg[scu_pkg::Q_RXIE];
							pcnt_next = 3'h0;
							fin = 1'b1;
						end
					end
				end
			end
			scu_pkg::ST_NACK: begin
				if (tick) begin
					bit_next = bit_reg + 4'h1;
					if (bit_reg == {3'h0, ccon_reg[scu_pkg::C_PD]}) begin // RQ22
						fin = 1'b1;
					end
				end
			end
			default: st_next = scu_pkg::ST_IDLE;
		endcase
		if (fin) begin
			st_next = scu_pkg::ST_IDLE;
			gtc_next = 9'h000; // RQ23
			wtc_next = 24'h000000; // RQ23
		end else if (run && tick && st_reg == scu_pkg::ST_IDLE) begin // RQ21
			if (gtc_reg != 9'h1FF) begin
				gtc_next = gtc_reg + 9'h001;
			end
			if (wtc_reg != 24'hFFFFFF) begin
				wtc_next = wtc_reg + 24'h000001;
			end
			if (gt_reg[8:0] != 9'h000 && gtc_next == gt_reg[8:0]) begin
				cint_next[scu_pkg::I_GIF] = 1'b1; // RQ1 RQ23
			end
			if ({wth_reg[7:0], wtl_reg} != 24'h000000
				&& wtc_next == {wth_reg[7:0], wtl_reg}) begin
				cint_next[scu_pkg::I_WIF] = 1'b1; // RQ1 RQ23
			end
		end
		if (!run) begin
			st_next = scu_pkg::ST_IDLE; // RQ8
		end
		// open drain: drive only for a zero on the line
		drv_next = (st_next == scu_pkg::ST_NACK)
			|| (st_next == scu_pkg::ST_TX && !sh_next[0]);
		err_next = irq_reg[scu_pkg::Q_ERIE] && ( // RQ4
			(cint_reg[scu_pkg::I_GIF] && cint_reg[scu_pkg::I_GIE])
			|| (cint_reg[scu_pkg::I_WIF] && cint_reg[scu_pkg::I_WIE])
			|| (cint_reg[scu_pkg::I_TIF] && cint_reg[scu_pkg::I_TIE] && t0)
			|| (cint_reg[scu_pkg::I_RIF] && cint_reg[scu_pkg::I_RIE] && t0)
			|| (stat_reg[scu_pkg::S_PARITY_ERROR_FLAG] && cint_reg[scu_pkg::I_PIE])); // RQ19 RQ20
	end

	always_ff @(posedge sys_clk) begin
		sy1_reg <= card_io_in;
		sy2_reg <= sy1_reg;
		if (!rst_n) begin
			mode_reg <= scu_pkg::RST_VAL;
			stat_reg <= scu_pkg::RST_VAL;
			baud_reg <= scu_pkg::RST_VAL;
			ccon_reg <= scu_pkg::RST_VAL;
			cint_reg <= scu_pkg::RST_VAL;
			gt_reg <= scu_pkg::RST_VAL;
			wtl_reg <= scu_pkg::RST_VAL;
			wth_reg <= scu_pkg::RST_VAL;
			irq_reg <= scu_pkg::RST_VAL;
			rdata_reg <= scu_pkg::RST_VAL;
			etu_reg <= scu_pkg::RST_VAL;
			txb_reg <= 9'h000;
			gtc_reg <= 9'h000;
			wtc_reg <= 24'h000000;
			rxd_reg <= 8'h00;
			sh_reg <= 10'h3FF;
			rsh_reg <= 10'h3FF;
			bit_reg <= 4'h0;
			try_reg <= 3'h0;
			pcnt_reg <= 3'h0;
			{txf_reg, rxr_reg, nack_reg, drv_reg} <= 4'h0;
			{rxi_reg, err_reg, last_reg} <= 3'h0;
			prev_reg <= 1'b1;
			st_reg <= scu_pkg::ST_IDLE;
		end else begin
			mode_reg <= mode_next;
			stat_reg <= stat_next;
			baud_reg <= baud_next;
			ccon_reg <= ccon_next;
			cint_reg <= cint_next;
			gt_reg <= gt_next;
			wtl_reg <= wtl_next;
			wth_reg <= wth_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
			etu_reg <= etu_next;
			txb_reg <= txb_next;
			gtc_reg <= gtc_next;
			wtc_reg <= wtc_next;
			rxd_reg <= rxd_next;
			sh_reg <= sh_next;
			rsh_reg <= rsh_next;
			bit_reg <= bit_next;
			try_reg <= try_next;
			pcnt_reg <= pcnt_next;
			{txf_reg, rxr_reg, nack_reg, drv_reg} <= {txf_next, rxr_next, nack_next, drv_next};
			{rxi_reg, err_reg, last_reg} <= {rxi_next, err_next, last_next};
			prev_reg <= sy2_reg;
			st_reg <= st_next;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_gt_match;
		(run && tick && st_reg == scu_pkg::ST_IDLE && gt_reg[8:0] != 9'h000
			&& gtc_reg + 9'h001 == gt_reg[8:0]) |=> cint_reg[scu_pkg::I_GIF];
	endproperty
	a_gt_match: assert property (p_gt_match) else $error("guard flag missed"); // RQ23
	property p_wt_count;
		(run && tick && st_reg == scu_pkg::ST_IDLE && st_next == scu_pkg::ST_IDLE
			&& wtc_reg != 24'hFFFFFF) |=> (wtc_reg == $past(wtc_reg) + 24'h000001);
	endproperty
	a_wt_count: assert property (p_wt_count) else $error("wait count slip"); // RQ21
	property p_etu_step;
		(st_reg == scu_pkg::ST_TX && !tick && st_next == scu_pkg::ST_TX)
			|=> (etu_reg == $past(etu_reg) + 16'h0001);
	endproperty
	a_etu_step: assert property (p_etu_step) else $error("etu count slip"); // RQ2
	property p_err_gate;
		error_irq |-> $past(irq_reg[scu_pkg::Q_ERIE]);
	endproperty
	a_err_gate: assert property (p_err_gate) else $error("error irq ungated"); // RQ4
	property p_sticky;
		(cint_reg[scu_pkg::I_GIF] && !(reg_wr && reg_addr == scu_pkg::A_CINT))
			|=> cint_reg[scu_pkg::I_GIF];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped"); // RQ3
	property p_disabled;
		!run |=> (st_reg == scu_pkg::ST_IDLE && !card_io_oe);
	endproperty
	a_disabled: assert property (p_disabled) else $error("active while off"); // RQ8
	property p_tx_start;
		(st_reg == scu_pkg::ST_IDLE && run && stat_reg[scu_pkg::S_TXEN] && txf_reg)
			|=> (st_reg == scu_pkg::ST_TX && card_io_oe);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start bit"); // RQ12
	property p_t1_nack;
		ccon_reg[scu_pkg::C_PROT] |-> (st_reg != scu_pkg::ST_NACK);
	endproperty
	a_t1_nack: assert property (p_t1_nack) else $error("nack under T=1"); // RQ22
	property p_echo;
		(run && st_reg == scu_pkg::ST_CHK && tick && bit_reg == 4'h1 && !nack_reg
			&& irq_reg[scu_pkg::Q_RXIE]) |=> rx_irq;
	endproperty
	a_echo: assert property (p_echo) else $error("no receive irq on send"); // RQ15
	c_tx: cover property (st_reg == scu_pkg::ST_CHK ##1 st_reg == scu_pkg::ST_IDLE);
	c_rx: cover property (st_reg == scu_pkg::ST_RX ##1 rx_irq);
	c_nack: cover property (st_reg == scu_pkg::ST_NACK);
endmodule : scu_card_port

// ===== tb/scu_card_model.sv
// Purpose: behavioural card on the shared open-drain data line
// Assumes: line idles high through a pull-up; ETU given in ns
// Notes: sends in direct convention only; nack_left sets how many NACKs follow
`timescale 1ns/1ps
module scu_card_model #(
	parameter int ETU_NS = 200
) (
	input  wire logic line,
	input  wire logic listen,
	output logic      pull_low
);
	logic [7:0] raw;
	logic       par;
	int         got;
	int         nack_left;

	initial begin
		pull_low = 1'b0;
		got = 0;
		nack_left = 0;
	end

	// raw keeps line levels in arrival order, so the bench can judge bit order
	always begin
		@(negedge line);
		if (listen) begin
			#(ETU_NS / 2);
			for (int i = 0; i < 8; i++) begin
				#(ETU_NS);
				raw[i] = line;
			end
			#(ETU_NS);
			par = line;
			got++;
			if (nack_left > 0) begin
				// covers the middle of the first guard etu
				#(ETU_NS / 2);
				pull_low = 1'b1;
				#(ETU_NS);
				pull_low = 1'b0;
				nack_left--;
			end
		end
	end

	task automatic send(input logic [7:0] b, input logic bad);
		#37;
		pull_low = 1'b1;
		#(ETU_NS);
		for (int i = 0; i < 9; i++) begin
			pull_low = (i < 8) ? ~b[i] : ~((^b) ^ bad);
			#(ETU_NS);
		end
		pull_low = 1'b0;
		#(2 * ETU_NS);
	endtask : send
endmodule : scu_card_model

// ===== tb/scu_card_port_tb_top.sv
// Purpose: self-checking bench for the card-mode serial port
// Assumes: divisor 7 gives an etu of 8 sys_clk cycles, 200 ns
// Notes: line is pulled up; port and card model both pull it low
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin err_total++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, ac); end end
module scu_card_port_tb_top;
	localparam int CEIL = 30000;
	logic        sys_clk;
	logic        rst_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        card_io_out;
	logic        card_io_oe;
	logic        rx_irq;
	logic        error_irq;
	logic [2:0]  error_irq_priority;
	logic        tx_last_done;
	logic        line;
	logic        pull_low;
	logic        listen;
	logic [15:0] v;
	logic [3:0]  ta [9];
	logic [15:0] tm [9];
	int          err_total;
	int          num_checks;
	int          cyc;
	int          rx_cnt;
	int          last_cnt;
	int          oe_cnt;
	int          n;

	assign line = (card_io_oe ? card_io_out : 1'b1) & ~pull_low;

	scu_card_port DUT (
		.sys_clk            (sys_clk),
		.rst_n              (rst_n),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.card_io_in         (line),
		.card_io_out        (card_io_out),
		.card_io_oe         (card_io_oe),
		.rx_irq             (rx_irq),
		.error_irq          (error_irq),
		.error_irq_priority (error_irq_priority),
		.tx_last_done       (tx_last_done)
	);

	scu_card_model #(.ETU_NS(200)) card (.line(line), .listen(listen), .pull_low(pull_low));

	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc++;
		rx_cnt += int'(rx_irq === 1'b1);
		last_cnt += int'(tx_last_done === 1'b1);
		oe_cnt += int'(card_io_oe === 1'b1);
		if (cyc == CEIL) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd

	task automatic chk(input string nm, input logic [3:0] a, input logic [15:0] ex);
		logic [15:0] d;
		rd(a, d);
		`CHK(nm, ex, d)
	endtask : chk

	// bounded waits: a silent port must not hang the run
	task automatic wait_rx(input int lim);
		int k;
		k = rx_cnt;
		for (int i = 0; i < lim && rx_cnt == k; i++) @(negedge sys_clk);
	endtask : wait_rx

	task automatic wait_err(input int lim);
		for (int i = 0; i < lim && error_irq !== 1'b1; i++) @(negedge sys_clk);
	endtask : wait_err

	task automatic cfg(input logic [15:0] st, cc, ci, iq);
		wr(scu_pkg::A_MODE, 16'h0006);
		wr(scu_pkg::A_STAT, st);
		wr(scu_pkg::A_CCON, cc);
		wr(scu_pkg::A_CINT, ci);
		wr(scu_pkg::A_IRQ, iq);
		wr(scu_pkg::A_MODE, 16'h8006);
	endtask : cfg

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	initial begin
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		listen = 1'b0;
		err_total = 0;
		num_checks = 0;
		cyc = 0;
		rx_cnt = 0;
		last_cnt = 0;
		oe_cnt = 0;
		ta = '{scu_pkg::A_CCON, scu_pkg::A_CINT, scu_pkg::A_GT, scu_pkg::A_WTL,
			scu_pkg::A_WTH, scu_pkg::A_IRQ, scu_pkg::A_BAUD, scu_pkg::A_MODE, 4'hB};
		tm = '{scu_pkg::CCON_WM, scu_pkg::CIE_WM, scu_pkg::GT_WM, 16'hFFFF,
			scu_pkg::WTH_WM, scu_pkg::IRQ_WM, 16'hFFFF, scu_pkg::MODE_WM, 16'h0000};
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			// status shows the idle bit after reset
			chk("reset value", 4'(i), (i == 1) ? 16'h0100 : scu_pkg::RST_VAL);
		end
		for (int i = 0; i < 9; i++) begin
			wr(ta[i], 16'hFFFF);
			chk("write mask", ta[i], tm[i]);
		end
		`CHK("priority", 3'h7, error_irq_priority)
		for (int i = 0; i < 9; i++) wr(ta[i], 16'h0000);
		// transmit, direct convention, last flag set
		wr(scu_pkg::A_BAUD, 16'h0007);
		wr(scu_pkg::A_WTL, 16'h0005);
		cfg(16'h0400, 16'h0003, 16'h0002, 16'h0003);
		listen = 1'b1;
		wr(scu_pkg::A_TXD, 16'h80A5);
		wait_rx(400);
		`CHK("card byte", 8'hA5, card.raw)
		`CHK("card parity", 1'b0, card.par)
		`CHK("echo irq", 1, rx_cnt)
		chk("echo data", scu_pkg::A_RXD, 16'h00A5);
		`CHK("last pulse", 1, last_cnt)
		// inverse convention, no last flag
		cfg(16'h0400, 16'h000B, 16'h0000, 16'h0003);
		wr(scu_pkg::A_TXD, 16'h0031);
		wait_rx(400);
		`CHK("inverse byte", 8'h73, card.raw)
		`CHK("inverse parity", 1'b0, card.par)
		`CHK("last pulse", 1, last_cnt)
		// nothing moves while the port is off
		wr(scu_pkg::A_MODE, 16'h0006);
		n = card.got;
		wr(scu_pkg::A_TXD, 16'h0055);
		repeat (200) @(posedge sys_clk);
		`CHK("idle while off", n, card.got)
		wr(scu_pkg::A_MODE, 16'h8006);
		wait_rx(400);
		`CHK("sent after on", n + 1, card.got)
		`CHK("inverse byte", 8'h55, card.raw)
		// receive under T=1 with guard 3 and wait 5 etu
		listen = 1'b0;
		wr(scu_pkg::A_GT, 16'h0003);
		wr(scu_pkg::A_WTL, 16'h0005);
		cfg(16'h1000, 16'h0003, 16'h0003, 16'h0002);
		fork
			card.send(8'h3C, 1'b0);
		join_none
		wait_rx(400);
		chk("flags at char end", scu_pkg::A_CINT, 16'h0003);
		chk("rx data", scu_pkg::A_RXD, 16'h003C);
		repeat (64) @(posedge sys_clk);
		chk("count flags", scu_pkg::A_CINT, 16'h0303);
		`CHK("gated irq", 1'b0, error_irq)
		wr(scu_pkg::A_IRQ, 16'h0003);
		wait_err(10);
		`CHK("error irq", 1'b1, error_irq)
		wr(scu_pkg::A_CINT, 16'h0003);
		repeat (3) @(posedge sys_clk);
		`CHK("flags cleared", 1'b0, error_irq)
		// receive under T=0, bad parity, retry count 0
		cfg(16'h1000, 16'h0001, 16'h0020, 16'h0001);
		n = oe_cnt;
		card.send(8'h5A, 1'b1);
		wait_err(400);
		`CHK("nack driven", 1'b1, oe_cnt > n)
		`CHK("rx repeat irq", 1'b1, error_irq)
		rd(scu_pkg::A_CINT, v);
		`CHK("rx repeat flag", 16'h2020, v & 16'h3030)
		rd(scu_pkg::A_STAT, v);
		`CHK("parity flag", 1'b1, v[3])
		// receive under T=1, bad parity: kept, no nack
		cfg(16'h1000, 16'h0003, 16'h0000, 16'h0002);
		n = oe_cnt;
		card.send(8'hC3, 1'b1);
		`CHK("no nack", n, oe_cnt)
		chk("data kept", scu_pkg::A_RXD, 16'h00C3);
		rd(scu_pkg::A_STAT, v);
		`CHK("parity flag", 1'b1, v[3])
		// transmit under T=0 with the card refusing every copy
		cfg(16'h0400, 16'h0001, 16'h0010, 16'h0001);
		listen = 1'b1;
		card.nack_left = 8;
		wr(scu_pkg::A_TXD, 16'h0011);
		wait_err(1000);
		`CHK("tx repeat irq", 1'b1, error_irq)
		rd(scu_pkg::A_CINT, v);
		`CHK("tx repeat flag", 16'h1010, v & 16'h3030)
		end_of_test();
	end
endmodule : scu_card_port_tb_top
